//--- design/fmc_modem.sv
// Purpose: digital core of a 300-baud fsk modem
// Assumes: pins synchronous to clk_sys_i, axi4-lite register port
// Notes on behaviour
// [RL1] cts low after selected delay on rts fall
// [RL2] cts high at once when rts rises
// [RL3] terminal holds tx data mark until cts
// [RL4] three selects choose one of eight delays
// [RL5] delays within 1.7 ms of nominal
// [RL6] rts low enables modulator, high disables
// [RL7] carrier absent forces rx data high
// [RL8] channel select picks answer/originate or channel
// [RL9] standard select: 1 us, 0 international
// [RL10] self test retunes demodulator to transmit pair
// [RL11] system loops transmit back for self test
// [RL12] answer tone overrides carrier, holds cts high
// [RL13] tx data high mark, low space
// [RL14] international channel frequencies as tabled
// [RL15] us answer/originate frequencies as tabled
// [RL16] tones derived from 3.6864 mhz reference
// [RL17] sine built from sixteen steps per cycle
// [RL18] tx test is square at transmit frequency
// [RL19] detector decision exposed on probe pin
// [RL20] rx carrier is limited square wave
// [RL21] edge period compared to pair midpoint
// [RL22] idle carrier holds mid-scale step
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "fmc_cfg.svh"

module fmc_modem #(
	parameter int unsigned TICK_CYC = `FMC_DLY_TICK_CYC
) (
	// clock and reset
	input  wire logic                   clk_sys_i,
	input  wire logic                   arst_n_i,
	// register port
	input  wire fmc_pkg::fmc_axi_req_t  axi_req_i,
	output fmc_pkg::fmc_axi_rsp_t       axi_rsp_o,
	// modem pins
	input  wire fmc_pkg::fmc_pins_in_t  pins_i,
	output fmc_pkg::fmc_pins_out_t      pins_o
);
	import fmc_pkg::*;

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic [1:0] rst_sync;
	logic       rst_n;

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	fmc_state_t r;
	fmc_state_t next_r;

	logic [7:0]  tx_div;
	logic [15:0] rx_thr;
	logic        rx_hi_mark;
	logic        own_chan;
	logic [12:0] dly_len;
	logic        mod_on;
	logic        tone_on;
	logic        enable;
	logic [18:0] acc_sum;

	// sine step values, offset binary around mid-scale
	function automatic logic [7:0] sine_step(input logic [3:0] ph);
		logic [7:0] v;
		v = 8'h80;
		unique case (ph)
			4'h0: v = 8'h80;
			4'h1: v = 8'hb1;
			4'h2: v = 8'hda;
			4'h3: v = 8'hf6;
			4'h4: v = 8'hff;
			4'h5: v = 8'hf6;
			4'h6: v = 8'hda;
			4'h7: v = 8'hb1;
			4'h8: v = 8'h80;
			4'h9: v = 8'h4f;
			4'ha: v = 8'h26;
			4'hb: v = 8'h0a;
			4'hc: v = 8'h01;
			4'hd: v = 8'h0a;
			4'he: v = 8'h26;
			4'hf: v = 8'h4f;
		endcase
		return v;
	endfunction

	// ------------------------------------------------------------
	// tone and threshold selection
	// ------------------------------------------------------------
	always_comb begin
		enable  = r.ctrl[`FMC_CTRL_EN_BIT];
		tone_on = enable && pins_i.answer_tone_request;
		// [RL6] rts gates modulator
		mod_on  = enable && !pins_i.rts_n;
		tx_div  = 8'(`FMC_TONE_DIV(`FMC_F_CH2_SPACE));
		// [RL12] answer tone per standard
		if (tone_on) begin
			tx_div = pins_i.standard_sel ?
				8'(`FMC_TONE_DIV(`FMC_F_ABT_US)) :
				8'(`FMC_TONE_DIV(`FMC_F_ABT_INTL));
		end else begin
			// [RL8] [RL9] [RL13] pair and mark/space choice
			unique case ({pins_i.standard_sel, pins_i.channel_sel,
				pins_i.tx_data})
				// [RL14] international frequencies
				3'b000: tx_div = 8'(`FMC_TONE_DIV(`FMC_F_CH2_SPACE));
				3'b001: tx_div = 8'(`FMC_TONE_DIV(`FMC_F_CH2_MARK));
				3'b010: tx_div = 8'(`FMC_TONE_DIV(`FMC_F_CH1_SPACE));
				3'b011: tx_div = 8'(`FMC_TONE_DIV(`FMC_F_CH1_MARK));
				// [RL15] us frequencies
				3'b100: tx_div = 8'(`FMC_TONE_DIV(`FMC_F_ANS_SPACE));
				3'b101: tx_div = 8'(`FMC_TONE_DIV(`FMC_F_ANS_MARK));
				3'b110: tx_div = 8'(`FMC_TONE_DIV(`FMC_F_ORG_SPACE));
				3'b111: tx_div = 8'(`FMC_TONE_DIV(`FMC_F_ORG_MARK));
			endcase
		end
		// [RL10] self test listens on own pair, else the far pair
		own_chan = pins_i.loopback_check ? pins_i.channel_sel :
			!pins_i.channel_sel;
		rx_thr     = 16'(`FMC_MID_THR(`FMC_F_CH2_SPACE, `FMC_F_CH2_MARK));
		rx_hi_mark = 1'b0;
		unique case ({pins_i.standard_sel, own_chan})
			2'b00: begin
				rx_thr = 16'(`FMC_MID_THR(`FMC_F_CH2_SPACE,
					`FMC_F_CH2_MARK));
				rx_hi_mark = 1'b0;
			end
			2'b01: begin
				rx_thr = 16'(`FMC_MID_THR(`FMC_F_CH1_SPACE,
					`FMC_F_CH1_MARK));
				rx_hi_mark = 1'b0;
			end
			2'b10: begin
				rx_thr = 16'(`FMC_MID_THR(`FMC_F_ANS_SPACE,
					`FMC_F_ANS_MARK));
				rx_hi_mark = 1'b1;
			end
			2'b11: begin
				rx_thr = 16'(`FMC_MID_THR(`FMC_F_ORG_SPACE,
					`FMC_F_ORG_MARK));
				rx_hi_mark = 1'b1;
			end
		endcase
		// [RL4] [RL5] delay in 100 us ticks
		dly_len = 13'(`FMC_DLY0_US / `FMC_DLY_TICK_US);
		unique case (pins_i.delay_sel)
			3'd0: dly_len = 13'(`FMC_DLY0_US / `FMC_DLY_TICK_US);
			3'd1: dly_len = 13'(`FMC_DLY1_US / `FMC_DLY_TICK_US);
			3'd2: dly_len = 13'(`FMC_DLY2_US / `FMC_DLY_TICK_US);
			3'd3: dly_len = 13'(`FMC_DLY3_US / `FMC_DLY_TICK_US);
			3'd4: dly_len = 13'(`FMC_DLY4_US / `FMC_DLY_TICK_US);
			3'd5: dly_len = 13'(`FMC_DLY5_US / `FMC_DLY_TICK_US);
			3'd6: dly_len = 13'(`FMC_DLY6_US / `FMC_DLY_TICK_US);
			3'd7: dly_len = 13'(`FMC_DLY7_US / `FMC_DLY_TICK_US);
		endcase
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_r = r;

		// [RL16] fractional 3.6864 mhz reference tick
		acc_sum = {1'b0, r.ref_acc} + 19'(`FMC_REF_INC);
		if (acc_sum >= 19'(`FMC_REF_MOD)) begin
			next_r.ref_acc  = 18'(acc_sum - 19'(`FMC_REF_MOD));
			next_r.ref_tick = 1'b1;
		end else begin
			next_r.ref_acc  = acc_sum[17:0];
			next_r.ref_tick = 1'b0;
		end

		// [RL17] sixteen-step sine synthesis
		if (r.ref_tick) begin
			if (r.step_cnt + 8'h01 >= tx_div) begin
				next_r.step_cnt = 8'h00;
				next_r.phase    = r.phase + 4'h1;
			end else begin
				next_r.step_cnt = r.step_cnt + 8'h01;
			end
		end
		// [RL22] idle carrier at mid-scale
		if (mod_on || tone_on) begin
			next_r.car = sine_step(r.phase);
		end else begin
			next_r.car = `FMC_CAR_MID;
		end
		// [RL18] square at transmit frequency
		next_r.txt = r.phase[3];

		// [RL21] edge period against pair midpoint
		next_r.prev_rx = pins_i.rx_carrier;
		if (pins_i.rx_carrier && !r.prev_rx) begin
			next_r.per_cnt = 16'h0000;
			next_r.det     = (r.per_cnt < rx_thr) ~^ rx_hi_mark;
		end else if (r.per_cnt != 16'hffff) begin
			next_r.per_cnt = r.per_cnt + 16'h0001;
		end
		// [RL7] clamp rx data without carrier
		next_r.rxd = pins_i.carrier_present_n ? 1'b1 : next_r.det;

		// request-to-clear sequencing
		if (r.tick_cnt + 12'h001 >= 12'(TICK_CYC)) begin
			next_r.tick_cnt = 12'h000;
		end else begin
			next_r.tick_cnt = r.tick_cnt + 12'h001;
		end
		unique case (r.cts_st)
			CTS_IDLE: begin
				next_r.cts_n = 1'b1;
				// [RL1] start delay on rts low
				if (mod_on && !tone_on) begin
					next_r.dly_cnt  = 13'h0000;
					next_r.tick_cnt = 12'h000;
					next_r.cts_st   = CTS_WAIT;
				end
			end
			CTS_WAIT: begin
				// [RL2] [RL12] abort at once
				if (!mod_on || tone_on) begin
					next_r.cts_st = CTS_IDLE;
				// [RL1] delay elapsed
				end else if (r.dly_cnt >= dly_len) begin
					next_r.cts_st = CTS_CLEAR;
					next_r.cts_n  = 1'b0;
				end else if (r.tick_cnt + 12'h001 >= 12'(TICK_CYC)) begin
					next_r.dly_cnt = r.dly_cnt + 13'h0001;
				end
			end
			CTS_CLEAR: begin
				// [RL2] [RL12] release without delay
				if (!mod_on || tone_on) begin
					next_r.cts_st = CTS_IDLE;
					next_r.cts_n  = 1'b1;
				end
			end
			default: begin
				next_r.cts_st = CTS_IDLE;
				next_r.cts_n  = 1'b1;
			end
		endcase

		// register write: address and data in either order
		if (axi_req_i.awvalid && r.axi.awready) begin
			next_r.aw_have     = 1'b1;
			next_r.aw_addr     = axi_req_i.awaddr;
			next_r.axi.awready = 1'b0;
		end
		if (axi_req_i.wvalid && r.axi.wready) begin
			next_r.w_have     = 1'b1;
			next_r.w_data     = axi_req_i.wdata;
			next_r.w_strb     = axi_req_i.wstrb;
			next_r.axi.wready = 1'b0;
		end
		if (r.aw_have && r.w_have && !r.axi.bvalid) begin
			next_r.aw_have    = 1'b0;
			next_r.w_have     = 1'b0;
			next_r.axi.bvalid = 1'b1;
			if (r.aw_addr[7:2] == `FMC_REG_CTRL >> 2) begin
				next_r.axi.bresp = `FMC_RESP_OKAY;
				for (int i = 0; i < 4; i++) begin
					if (r.w_strb[i]) begin
						next_r.ctrl[i*8 +: 8] = r.w_data[i*8 +: 8];
					end
				end
			end else if (r.aw_addr[7:2] == `FMC_REG_STATUS >> 2) begin
				next_r.axi.bresp = `FMC_RESP_OKAY;
			end else begin
				next_r.axi.bresp = `FMC_RESP_SLVERR;
			end
		end
		if (r.axi.bvalid && axi_req_i.bready) begin
			next_r.axi.bvalid  = 1'b0;
			next_r.axi.awready = 1'b1;
			next_r.axi.wready  = 1'b1;
		end

		// register read
		if (axi_req_i.arvalid && r.axi.arready) begin
			next_r.axi.arready = 1'b0;
			next_r.axi.rvalid  = 1'b1;
			next_r.axi.rresp   = `FMC_RESP_OKAY;
			if (axi_req_i.araddr[7:2] == `FMC_REG_CTRL >> 2) begin
				next_r.axi.rdata = r.ctrl;
			end else if (axi_req_i.araddr[7:2] == `FMC_REG_STATUS >> 2)
				begin
				next_r.axi.rdata = {22'h000000, r.cts_st,
					pins_i.delay_sel, tone_on, mod_on, r.det, r.rxd,
					r.cts_n};
			end else begin
				next_r.axi.rdata = 32'h0000_0000;
				next_r.axi.rresp = `FMC_RESP_SLVERR;
			end
		end
		if (r.axi.rvalid && axi_req_i.rready) begin
			next_r.axi.rvalid  = 1'b0;
			next_r.axi.arready = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			r             <= '0;
			r.car         <= `FMC_CAR_MID;
			r.det         <= 1'b1;
			r.rxd         <= 1'b1;
			r.cts_n       <= 1'b1;
			r.cts_st      <= CTS_IDLE;
			r.ctrl        <= `FMC_CTRL_RST;
			r.axi.awready <= 1'b1;
			r.axi.wready  <= 1'b1;
			r.axi.arready <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign axi_rsp_o                 = r.axi;
	assign pins_o.tx_carrier         = r.car;
	assign pins_o.tx_test            = r.txt;
	assign pins_o.cts_n              = r.cts_n;
	assign pins_o.rx_data            = r.rxd;
	// [RL19] raw detector decision
	assign pins_o.detector_probe_out = r.det;

endmodule

//--- inc/fmc_cfg.svh
// Purpose: constants of the 300-baud fsk modem core
// Assumes: 20 MHz system clock, 3.6864 MHz tone reference
// Notes:   times in their own unit, counts derived from them
`ifndef FMC_CFG_SVH
`define FMC_CFG_SVH

// ----------------------------------------------------------------
// clocks
// ----------------------------------------------------------------
`define FMC_CLK_HZ        20000000
`define FMC_CLK_PERIOD_NS 50
`define FMC_REF_HZ        3686400
// fractional reference tick: add REF/100 per cycle, modulo CLK/100
`define FMC_REF_INC       (`FMC_REF_HZ / 100)
`define FMC_REF_MOD       (`FMC_CLK_HZ / 100)
`define FMC_SIN_STEPS     16

// ----------------------------------------------------------------
// tones in hz
// ----------------------------------------------------------------
`define FMC_F_CH2_SPACE   1850
`define FMC_F_CH2_MARK    1650
`define FMC_F_CH1_SPACE   1180
`define FMC_F_CH1_MARK    980
`define FMC_F_ANS_SPACE   2025
`define FMC_F_ANS_MARK    2225
`define FMC_F_ORG_SPACE   1070
`define FMC_F_ORG_MARK    1270
`define FMC_F_ABT_US      2025
`define FMC_F_ABT_INTL    2100
// reference ticks per sine step
`define FMC_TONE_DIV(f)   ((`FMC_REF_HZ / `FMC_SIN_STEPS) / (f))
// period threshold in clock cycles at the mid frequency of a pair
`define FMC_MID_THR(a, b) ((2 * `FMC_CLK_HZ) / ((a) + (b)))

// ----------------------------------------------------------------
// request-to-clear delays in us
// ----------------------------------------------------------------
`define FMC_DLY_TICK_US   100
`define FMC_DLY0_US       0
`define FMC_DLY1_US       26700
`define FMC_DLY2_US       40000
`define FMC_DLY3_US       60000
`define FMC_DLY4_US       133300
`define FMC_DLY5_US       213300
`define FMC_DLY6_US       266700
`define FMC_DLY7_US       426600
`define FMC_DLY_TICK_CYC  ((`FMC_DLY_TICK_US * 1000) / `FMC_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// register map and fields
// ----------------------------------------------------------------
`define FMC_REG_CTRL      8'h00
`define FMC_REG_STATUS    8'h04
`define FMC_CTRL_RST      32'h0000_0001
`define FMC_CTRL_EN_BIT   0
`define FMC_RESP_OKAY     2'b00
`define FMC_RESP_SLVERR   2'b10
`define FMC_CAR_MID       8'h80

`endif

//--- inc/fmc_pkg.sv
// Purpose: types of the 300-baud fsk modem core
// Assumes: axi4-lite with 32-bit data
// Notes:   constants live in fmc_cfg.svh
package fmc_pkg;

	typedef enum logic [1:0] {
		CTS_IDLE  = 2'b00,
		CTS_WAIT  = 2'b01,
		CTS_CLEAR = 2'b10
	} fmc_cts_st_t;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} fmc_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} fmc_axi_rsp_t;

	typedef struct packed {
		logic       rts_n;
		logic       tx_data;
		logic [2:0] delay_sel;
		logic       channel_sel;
		logic       standard_sel;
		logic       answer_tone_request;
		logic       loopback_check;
		logic       carrier_present_n;
		logic       rx_carrier;
	} fmc_pins_in_t;

	typedef struct packed {
		logic [7:0] tx_carrier;
		logic       tx_test;
		logic       cts_n;
		logic       rx_data;
		logic       detector_probe_out;
	} fmc_pins_out_t;

	typedef struct packed {
		logic [17:0]  ref_acc;
		logic         ref_tick;
		logic [7:0]   step_cnt;
		logic [3:0]   phase;
		logic [7:0]   car;
		logic         txt;
		logic         prev_rx;
		logic [15:0]  per_cnt;
		logic         det;
		logic         rxd;
		logic [11:0]  tick_cnt;
		logic [12:0]  dly_cnt;
		fmc_cts_st_t  cts_st;
		logic         cts_n;
		logic [31:0]  ctrl;
		logic         aw_have;
		logic [7:0]   aw_addr;
		logic         w_have;
		logic [31:0]  w_data;
		logic [3:0]   w_strb;
		fmc_axi_rsp_t axi;
	} fmc_state_t;

endpackage

//--- tb/fmc_modem_chk.sv
// Purpose: port checks on the modem core
// Assumes: bound to fmc_modem, one clock domain
// Notes:   reset disables every check
`timescale 1ns/100ps
module fmc_modem_chk #(
	parameter int unsigned TICK_CYC = 2000
) (
	// clock and reset
	input wire logic                   clk_sys_i,
	input wire logic                   arst_n_i,
	// observed ports
	input wire fmc_pkg::fmc_axi_req_t  axi_req_i,
	input wire fmc_pkg::fmc_axi_rsp_t  axi_rsp_o,
	input wire fmc_pkg::fmc_pins_in_t  pins_i,
	input wire fmc_pkg::fmc_pins_out_t pins_o
);
	import fmc_pkg::*;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);

	// ----
	// register bus
	// ----
	sequence s_wr_take;
		axi_req_i.awvalid && axi_rsp_o.awready &&
		axi_req_i.wvalid && axi_rsp_o.wready;
	endsequence
	sequence s_b_hs;
		axi_rsp_o.bvalid && axi_req_i.bready;
	endsequence
	wr_resp_a: assert property (s_wr_take |=>
		!axi_rsp_o.bvalid ##1 axi_rsp_o.bvalid)
		else $error("write response timing wrong");
	wr_done_a: assert property (s_b_hs |=>
		!axi_rsp_o.bvalid && axi_rsp_o.awready && axi_rsp_o.wready)
		else $error("write channel not freed");
	rd_resp_a: assert property (
		axi_req_i.arvalid && axi_rsp_o.arready |=>
		axi_rsp_o.rvalid && !axi_rsp_o.arready)
		else $error("read response timing wrong");
	rd_done_a: assert property (
		axi_rsp_o.rvalid && axi_req_i.rready |=>
		!axi_rsp_o.rvalid && axi_rsp_o.arready)
		else $error("read channel not freed");
	rd_unmapped_a: assert property (axi_req_i.arvalid &&
		axi_rsp_o.arready && axi_req_i.araddr[7:2] > 6'h01 |=>
		axi_rsp_o.rresp == 2'b10 && axi_rsp_o.rdata == 32'h0)
		else $error("unmapped read not refused");

	// ----
	// modem pins
	// ----
	cts_rise_a: assert property (
		$rose(pins_i.rts_n) |-> ##[1:2] pins_o.cts_n)
		else $error("cts not released");
	cts_tone_a: assert property (
		pins_i.answer_tone_request[*2] |=> pins_o.cts_n)
		else $error("cts low during answer tone");
	cts_cause_a: assert property (
		$fell(pins_o.cts_n) |-> !$past(pins_i.rts_n) &&
		!$past(pins_i.answer_tone_request))
		else $error("cts fell without request");
	rx_clamp_a: assert property (
		pins_i.carrier_present_n |=> pins_o.rx_data)
		else $error("rx data not clamped");
	idle_mid_a: assert property (
		(pins_i.rts_n && !pins_i.answer_tone_request)[*4] |->
		pins_o.tx_carrier == 8'h80)
		else $error("idle carrier not mid-scale");
endmodule

bind fmc_modem fmc_modem_chk #(.TICK_CYC(TICK_CYC)) fmc_modem_chk_inst (
	.clk_sys_i(clk_sys_i),
	.arst_n_i (arst_n_i),
	.axi_req_i(axi_req_i),
	.axi_rsp_o(axi_rsp_o),
	.pins_i   (pins_i),
	.pins_o   (pins_o)
);

//--- tb/fmc_term_model.sv
// Purpose: terminal and receive line model
// Assumes: loop path feeds transmit square back
// Notes:   silent line gives a changing pattern
`timescale 1ns/100ps
module fmc_term_model (
	// clock
	input  wire logic clk_sys_i,
	// terminal side
	input  wire logic cts_n_i,
	input  wire logic tx_bit_i,
	output logic      tx_data_o,
	// line side
	input  wire logic loop_i,
	input  wire logic tx_test_i,
	output logic      rx_carrier_o
);
	initial begin
		tx_data_o = 1'b1;
		rx_carrier_o = 1'b0;
	end
	always @(posedge clk_sys_i) begin
		tx_data_o <= cts_n_i ? 1'b1 : tx_bit_i;
		rx_carrier_o <= loop_i ? tx_test_i : ~rx_carrier_o;
	end
endmodule

//--- tb/tb_fmc_modem.sv
// Purpose: self-checking bench of the modem core
// Assumes: short delay tick for run time
// Notes:   bus tasks wait until answered
`timescale 1ns/100ps
`include "fmc_cfg.svh"
module tb_fmc_modem;
	import fmc_pkg::*;
	localparam int T = 2;
	logic          clk_sys_i;
	logic          arst_n_i;
	fmc_axi_req_t  req;
	fmc_axi_rsp_t  rsp;
	fmc_pins_in_t  pin;
	fmc_pins_in_t  pins_w;
	fmc_pins_out_t po;
	logic          tx_bit;
	logic          loop_en;
	logic          m_txd;
	logic          m_rxc;
	logic          moved;
	logic          last_tt;
	logic [31:0]   rd;
	logic [1:0]    rr;
	int            err_count = 0;
	int            checks = 0;
	int            cyc = 0;
	int            cnt = 0;
	int            per = 0;
	int            n;
	int            dl[8] = '{0, 267, 400, 600, 1333, 2133, 2667, 4266};

	assign pins_w = {pin.rts_n, m_txd, pin[8:1], m_rxc};
	fmc_modem #(.TICK_CYC(T)) fmc_modem_inst (.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i), .axi_req_i(req), .axi_rsp_o(rsp),
		.pins_i(pins_w), .pins_o(po));
	fmc_term_model fmc_term_model_inst (.clk_sys_i(clk_sys_i),
		.cts_n_i(po.cts_n), .tx_bit_i(tx_bit), .tx_data_o(m_txd),
		.loop_i(loop_en), .tx_test_i(po.tx_test), .rx_carrier_o(m_rxc));

	// ----
	// clock, timeout, period meter
	// ----
	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		cyc++;
		cnt++;
		if (po.tx_test && !last_tt) begin
			per = cnt;
			cnt = 0;
		end
		last_tt = po.tx_test;
		if (cyc == 90000) begin
			err_count++;
			finish_test();
		end
	end

	// ----
	// tasks
	// ----
	task automatic check(input string nm, input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("mismatch %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic finish_test();
		if (err_count == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		req <= '{awvalid:1'b1, awaddr:a, wvalid:1'b1, wdata:d,
			wstrb:4'hf, bready:1'b1, default:'0};
		forever begin
			@(posedge clk_sys_i);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
			if (rsp.bvalid) begin
				rr = rsp.bresp;
				req.bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic axi_rd(input logic [7:0] a);
		@(posedge clk_sys_i);
		req <= '{arvalid:1'b1, araddr:a, rready:1'b1, default:'0};
		forever begin
			@(posedge clk_sys_i);
			if (rsp.arready) req.arvalid <= 1'b0;
			if (rsp.rvalid) begin
				rd = rsp.rdata;
				rr = rsp.rresp;
				req.rready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic chk_per(input int f);
		int e;
		e = int'(real'(`FMC_REF_HZ / 16 / f) * 16.0 * `FMC_CLK_HZ
			/ `FMC_REF_HZ);
		check("tx period", (per >= e - 3 && per <= e + 3) ? e : per, e);
	endtask
	task automatic measure(input int f);
		repeat (2) @(posedge po.tx_test);
		repeat (4) @(posedge clk_sys_i);
		chk_per(f);
	endtask

	// ----
	// sequence
	// ----
	initial begin
		arst_n_i = 1'b0;
		req = '0;
		pin = '{rts_n:1'b1, carrier_present_n:1'b1, default:'0};
		tx_bit = 1'b1;
		loop_en = 1'b0;
		moved = 1'b0;
		repeat (16) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		axi_rd(`FMC_REG_CTRL);
		check("ctrl reset", rd, 32'h1);
		axi_wr(8'h10, 32'h1);
		check("bad wr resp", rr, `FMC_RESP_SLVERR);
		axi_rd(8'h10);
		check("bad rd resp", rr, `FMC_RESP_SLVERR);
		check("bad rd data", rd, 32'h0);
		axi_wr(`FMC_REG_CTRL, 32'h0);
		pin.rts_n <= 1'b0;
		repeat (40) @(posedge clk_sys_i);
		check("cts disabled", po.cts_n, 1'b1);
		check("carrier disabled", po.tx_carrier, 8'h80);
		pin.rts_n <= 1'b1;
		axi_wr(`FMC_REG_CTRL, 32'h1);
		check("ctrl wr resp", rr, `FMC_RESP_OKAY);
		for (int k = 0; k < 8; k++) begin
			pin.delay_sel <= k[2:0];
			repeat (2) @(posedge clk_sys_i);
			pin.rts_n <= 1'b0;
			n = 0;
			while (po.cts_n !== 1'b0) begin
				@(posedge clk_sys_i);
				n++;
				if (po.tx_carrier !== 8'h80) moved = 1'b1;
			end
			check("cts delay", (n >= (dl[k] - 17) * T &&
				n <= (dl[k] + 17) * T + 4) ? dl[k] * T : n,
				dl[k] * T);
			axi_rd(`FMC_REG_STATUS);
			check("status", {rd[7:3], rd[0]}, {k[2:0], 3'b010});
			pin.rts_n <= 1'b1;
			repeat (2) @(posedge clk_sys_i);
			check("cts release", po.cts_n, 1'b1);
			repeat (2) @(posedge clk_sys_i);
			check("idle carrier", po.tx_carrier, 8'h80);
		end
		check("carrier moved", moved, 1'b1);
		chk_per(`FMC_F_CH2_MARK);
		pin.channel_sel <= 1'b0;
		pin.standard_sel <= 1'b1;
		pin.loopback_check <= 1'b1;
		pin.carrier_present_n <= 1'b0;
		pin.delay_sel <= 3'b000;
		pin.rts_n <= 1'b0;
		loop_en <= 1'b1;
		measure(`FMC_F_ANS_MARK);
		check("rx mark", po.rx_data, 1'b1);
		check("probe mark", po.detector_probe_out, 1'b1);
		tx_bit <= 1'b0;
		measure(`FMC_F_ANS_SPACE);
		check("rx space", po.rx_data, 1'b0);
		check("probe space", po.detector_probe_out, 1'b0);
		pin.carrier_present_n <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		check("rx clamp", po.rx_data, 1'b1);
		pin.standard_sel <= 1'b0;
		pin.answer_tone_request <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		check("cts tone", po.cts_n, 1'b1);
		measure(`FMC_F_ABT_INTL);
		check("probe intl", po.detector_probe_out, 1'b0);
		finish_test();
	end
endmodule
